// File: design/rfc_top.sv
// RC oscillator network driver and gated down-counter with AXI4-Lite access
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`include "rfc_map.svh"
module rfc_top #(
    parameter int CW = 8,
    parameter int AW = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Oscillator pins
    input wire logic osc_feedback_input,
    input wire logic window_timer_clock,
    output logic ref_resistor_drive,
    output logic ref_drive_enable,
    output logic first_sensor_drive,
    output logic first_sensor_enable,
    output logic second_sensor_drive,
    output logic second_sensor_enable,
    // Status
    output logic measure_stop_flag,
    output logic irq
);
    initial begin
        if (CW != 8) $error("rfc_top: stage width must be 8");
        if (AW < 8) $error("rfc_top: address width below 8");
    end

    // ****************************************
    // Synchronisers
    // ****************************************
    logic fb_level;
    logic fb_fall;
    logic wc_level;
    logic wc_fall;

    rfc_sync_fall u_fb_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(osc_feedback_input),
        .level(fb_level),
        .fall(fb_fall)
    );

    rfc_sync_fall u_wc_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(window_timer_clock),
        .level(wc_level),
        .fall(wc_fall)
    );

    // ****************************************
    // Registers and bus slave
    // ****************************************
    logic [7:0] stop_mode_reg;
    logic [7:0] net_sel_reg;
    logic [3:0] tmr_en_reg;
    logic [7:0] win_reg;
    logic [7:0] status_reg;
    logic [7:0] irq_en_reg;
    logic [AW-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic wr_go;
    logic [AW-1:0] wr_addr;
    logic [7:0] wr_byte;
    logic [CW-1:0] cnt_val [3];
    logic cnt_load [3];
    logic cnt_dec [3];
    logic cnt_borrow [3];
    logic done_evt;
    rfc_pkg::rfc_stop_mode_t mode;
    rfc_pkg::rfc_state_t state_reg;

    assign mode = rfc_pkg::rfc_stop_mode_t'(
        stop_mode_reg[`RFC_MODE_HI:`RFC_MODE_LO]); // [R4]
    assign wr_go = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    assign wr_addr = awaddr_reg;
    assign wr_byte = wdata_reg[7:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wdata_reg <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wstrb[0] ? s_axi_wdata : 32'h00000000;
        end else if (wr_go) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_held_reg & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready <= ~w_held_reg & ~s_axi_wready & ~s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RFC_AXI_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            if (wr_addr == AW'(`RFC_ADDR_STOP_MODE) ||
                wr_addr == AW'(`RFC_ADDR_NET_SEL) ||
                (wr_addr >= AW'(`RFC_ADDR_TMR_EN) &&
                 wr_addr <= AW'(`RFC_ADDR_IRQ_EN) &&
                 wr_addr[1:0] == 2'b00)) begin
                s_axi_bresp <= `RFC_AXI_OKAY;
            end else begin
                s_axi_bresp <= `RFC_AXI_DECERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_mode_reg <= `RFC_STOP_MODE_RST;
            net_sel_reg <= `RFC_NET_SEL_RST; // [R1]
            tmr_en_reg <= 4'h0;
            irq_en_reg <= 8'h00;
        end else if (wr_go) begin
            if (wr_addr == AW'(`RFC_ADDR_STOP_MODE)) begin
                stop_mode_reg <= wr_byte;
            end else if (wr_addr == AW'(`RFC_ADDR_NET_SEL)) begin
                net_sel_reg <= wr_byte & 8'h30;
            end else if (wr_addr == AW'(`RFC_ADDR_TMR_EN)) begin
                tmr_en_reg <= wr_byte[3:0];
            end else if (wr_addr == AW'(`RFC_ADDR_IRQ_EN)) begin
                irq_en_reg <= wr_byte & 8'h04;
            end
        end
    end

    // Sticky done bit, set wins over a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= 8'h00;
        end else if (done_evt) begin
            status_reg[`RFC_ST_DONE] <= 1'b1; // [R13]
        end else if (wr_go && wr_addr == AW'(`RFC_ADDR_STATUS) &&
                     wr_byte[`RFC_ST_DONE]) begin
            status_reg[`RFC_ST_DONE] <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_reg & irq_en_reg); // [R13]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RFC_AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RFC_AXI_OKAY;
            if (s_axi_araddr == AW'(`RFC_ADDR_STOP_MODE)) begin
                s_axi_rdata <= {24'h000000, stop_mode_reg};
            end else if (s_axi_araddr == AW'(`RFC_ADDR_NET_SEL)) begin
                s_axi_rdata <= {24'h000000, net_sel_reg};
            end else if (s_axi_araddr == AW'(`RFC_ADDR_TMR_EN)) begin
                s_axi_rdata <= {28'h0000000, tmr_en_reg};
            end else if (s_axi_araddr == AW'(`RFC_ADDR_CNT0)) begin
                s_axi_rdata <= {24'h000000, cnt_val[0]}; // [R14]
            end else if (s_axi_araddr == AW'(`RFC_ADDR_CNT1)) begin
                s_axi_rdata <= {24'h000000, cnt_val[1]}; // [R14]
            end else if (s_axi_araddr == AW'(`RFC_ADDR_CNT2)) begin
                s_axi_rdata <= {24'h000000, cnt_val[2]}; // [R14]
            end else if (s_axi_araddr == AW'(`RFC_ADDR_WIN)) begin
                s_axi_rdata <= {24'h000000, win_reg};
            end else if (s_axi_araddr == AW'(`RFC_ADDR_STATUS)) begin
                s_axi_rdata <= {24'h000000, status_reg} |
                    {27'h0000000, state_reg == rfc_pkg::RFC_GATE,
                     measure_stop_flag, 3'h0};
            end else if (s_axi_araddr == AW'(`RFC_ADDR_IRQ_EN)) begin
                s_axi_rdata <= {24'h000000, irq_en_reg};
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `RFC_AXI_DECERR;
            end
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= ~s_axi_arready;
        end
    end

    // ****************************************
    // Network drivers
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_drive_enable <= 1'b0;
            first_sensor_enable <= 1'b0;
            second_sensor_enable <= 1'b0;
            ref_resistor_drive <= 1'b0;
            first_sensor_drive <= 1'b0;
            second_sensor_drive <= 1'b0;
        end else begin
            ref_drive_enable <= net_sel_reg[`RFC_SEL_HI:`RFC_SEL_LO] ==
                rfc_pkg::RFC_NET_REF; // [R1]
            first_sensor_enable <= net_sel_reg[`RFC_SEL_HI:`RFC_SEL_LO] ==
                rfc_pkg::RFC_NET_FIRST; // [R1]
            second_sensor_enable <= net_sel_reg[`RFC_SEL_HI:`RFC_SEL_LO] ==
                rfc_pkg::RFC_NET_SECOND; // [R1]
            ref_resistor_drive <= ~fb_level; // [R2]
            first_sensor_drive <= ~fb_level; // [R2]
            second_sensor_drive <= ~fb_level; // [R2]
        end
    end

    // ****************************************
    // Measurement sequencer
    // ****************************************
    logic [7:0] presc_reg;
    logic [7:0] presc_mask;
    logic tick;
    logic close_gate;

    assign presc_mask = (8'h01 << stop_mode_reg[`RFC_PRESC_HI:`RFC_PRESC_LO])
        - 8'h01;
    assign tick = (presc_reg & presc_mask) == presc_mask;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_reg <= 8'h00;
        end else begin
            presc_reg <= presc_reg + 8'h01;
        end
    end

    always_comb begin
        close_gate = 1'b0;
        case (mode)
            rfc_pkg::RFC_STOP_UNDERFLOW: close_gate = win_reg == 8'h00; // [R7]
            rfc_pkg::RFC_STOP_FB_CYCLE: close_gate = fb_fall; // [R10]
            rfc_pkg::RFC_STOP_WIN_CYCLE: close_gate = wc_fall; // [R12]
            default: close_gate = 1'b0;
        endcase
    end

    assign done_evt = state_reg == rfc_pkg::RFC_GATE && close_gate &&
        tmr_en_reg[0] && mode != rfc_pkg::RFC_STOP_OFF;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= rfc_pkg::RFC_IDLE;
        end else if (!tmr_en_reg[0] || mode == rfc_pkg::RFC_STOP_OFF) begin
            state_reg <= rfc_pkg::RFC_IDLE;
        end else begin
            case (state_reg)
                rfc_pkg::RFC_IDLE: begin
                    state_reg <= rfc_pkg::RFC_ARMED;
                end
                rfc_pkg::RFC_ARMED: begin
                    if (mode == rfc_pkg::RFC_STOP_UNDERFLOW &&
                        tmr_en_reg[`RFC_EN_WIN]) begin
                        state_reg <= rfc_pkg::RFC_GATE; // [R6] [R8]
                    end else if (mode == rfc_pkg::RFC_STOP_FB_CYCLE &&
                                 fb_fall) begin
                        state_reg <= rfc_pkg::RFC_GATE; // [R9]
                    end else if (mode == rfc_pkg::RFC_STOP_WIN_CYCLE &&
                                 wc_fall) begin
                        state_reg <= rfc_pkg::RFC_GATE; // [R11]
                    end
                end
                rfc_pkg::RFC_GATE: begin
                    if (close_gate) begin
                        state_reg <= rfc_pkg::RFC_DONE;
                    end
                end
                default: begin
                    state_reg <= rfc_pkg::RFC_DONE;
                end
            endcase
        end
    end

    // Level in modes 1 and 2, single pulse in mode 3
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            measure_stop_flag <= 1'b0;
        end else if (done_evt) begin
            measure_stop_flag <= 1'b1; // [R10] [R12]
        end else if (mode == rfc_pkg::RFC_STOP_WIN_CYCLE ||
                     state_reg != rfc_pkg::RFC_DONE) begin
            measure_stop_flag <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win_reg <= 8'h00;
        end else if (wr_go && wr_addr == AW'(`RFC_ADDR_WIN)) begin
            win_reg <= wr_byte;
        end else if (mode == rfc_pkg::RFC_STOP_UNDERFLOW &&
                     state_reg == rfc_pkg::RFC_GATE && wc_fall &&
                     win_reg != 8'h00) begin
            win_reg <= win_reg - 8'h01; // [R7]
        end
    end

    // ****************************************
    // Chained down-counter
    // ****************************************
    logic gate_open;
    logic base_dec;

    assign gate_open = state_reg == rfc_pkg::RFC_GATE && !close_gate &&
        !measure_stop_flag;

    always_comb begin
        base_dec = 1'b0;
        case (mode)
            rfc_pkg::RFC_STOP_OFF: base_dec = tmr_en_reg[0] & fb_fall;
            rfc_pkg::RFC_STOP_FB_CYCLE: base_dec = gate_open & tick; // [R9]
            default: base_dec = gate_open & fb_fall; // [R7] [R11]
        endcase
    end

    always_comb begin
        cnt_dec[0] = base_dec; // [R3]
        cnt_dec[1] = cnt_borrow[0] & tmr_en_reg[1]; // [R5] [R18]
        cnt_dec[2] = cnt_borrow[1] & tmr_en_reg[2] &
            (mode == rfc_pkg::RFC_STOP_FB_CYCLE); // [R5] [R18]
    end

    for (genvar i = 0; i < 3; i++) begin : g_stage
        assign cnt_load[i] = wr_go &&
            wr_addr == AW'(`RFC_ADDR_CNT0) + AW'(4 * i);
        rfc_down_counter #(.W(CW)) u_stage (
            .aclk(aclk),
            .aresetn(aresetn),
            .load(cnt_load[i]),
            .load_value(wr_byte),
            .dec(cnt_dec[i]),
            .value(cnt_val[i]),
            .borrow(cnt_borrow[i])
        );
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_one_network: assert property ( // [R1]
        $onehot0({ref_drive_enable, first_sensor_enable, second_sensor_enable}))
        else $error("more than one network driven");
    chk_drive_inverts: assert property ( // [R2]
        ##1 ref_drive_enable |-> ref_resistor_drive == !$past(fb_level))
        else $error("network drive not inverse of feedback");
    chk_count_down: assert property ( // [R3]
        cnt_dec[0] && !cnt_load[0] |=> cnt_val[0] == $past(cnt_val[0]) - 8'h01)
        else $error("counter did not decrement");
    chk_width_limit: assert property ( // [R5]
        mode != rfc_pkg::RFC_STOP_FB_CYCLE && !cnt_load[2]
        |=> cnt_val[2] == $past(cnt_val[2]))
        else $error("third stage counted outside feedback mode");
    chk_underflow_arm: assert property ( // [R6]
        state_reg == rfc_pkg::RFC_ARMED && !tmr_en_reg[`RFC_EN_WIN] &&
        mode == rfc_pkg::RFC_STOP_UNDERFLOW |=> state_reg != rfc_pkg::RFC_GATE)
        else $error("gate opened without window enable");
    chk_window_halt: assert property ( // [R7]
        done_evt && mode == rfc_pkg::RFC_STOP_UNDERFLOW
        |=> win_reg == 8'h00 && state_reg == rfc_pkg::RFC_DONE)
        else $error("window end not at zero");
    chk_fb_stop: assert property ( // [R10]
        state_reg == rfc_pkg::RFC_GATE && fb_fall && tmr_en_reg[0] &&
        mode == rfc_pkg::RFC_STOP_FB_CYCLE |=> measure_stop_flag)
        else $error("second feedback fall did not stop");
    chk_win_pulse: assert property ( // [R12]
        done_evt && mode == rfc_pkg::RFC_STOP_WIN_CYCLE
        |=> measure_stop_flag ##1 !measure_stop_flag)
        else $error("window-cycle stop not a pulse");
    chk_irq_raise: assert property ( // [R13]
        done_evt && irq_en_reg[2] |=> status_reg[2] ##1 irq)
        else $error("interrupt not raised at end");
    cov_underflow_done: cover property (
        done_evt && mode == rfc_pkg::RFC_STOP_UNDERFLOW);
    cov_fb_done: cover property (done_evt && cnt_dec[2] == 1'b0 &&
        mode == rfc_pkg::RFC_STOP_FB_CYCLE);
    cov_win_done: cover property (done_evt &&
        mode == rfc_pkg::RFC_STOP_WIN_CYCLE);
    cov_chain_24: cover property (cnt_dec[2]);
endmodule // rfc_top

// File: inc/rfc_map.svh
// Register map, field positions and reset values of the RC frequency counter
// What this block does
// (R1) Network select picks one oscillator, default off
// (R2) Selected output drives inverted feedback, others float
// (R3) Enabled counter decrements its preloaded value
// (R4) Stop-mode field encodes gating, resets off
// (R5) Width 8/16/24 follows enables; 24 mode2 only
// (R6) Underflow mode waits for counters and window
// (R7) Window timer counts down, halts at zero
// (R8) Underflow window may deviate two window cycles
// (R9) Feedback mode: first fall opens gate window
// (R10) Feedback mode: second fall sets stop flag
// (R11) Window-clock mode: two falls bound the gate
// (R12) Window-clock mode: second fall pulses stop flag
// (R13) Measurement end raises counter-0 interrupt if enabled
// (R14) Remaining counter contents stay readable afterwards
// (R15) Software enables network output before counter
// (R16) Software enables window or counter-0 last
// (R17) Feedback and window clock synchronised, falls detected
// (R18) Lower counter borrow decrements next higher counter
`ifndef RFC_MAP_SVH
`define RFC_MAP_SVH
// ****************************************
// Register indices and byte addresses
// ****************************************
`define RFC_IDX_STOP_MODE 8'h01
`define RFC_IDX_NET_SEL 8'h2f
`define RFC_ADDR_STOP_MODE (`RFC_IDX_STOP_MODE << 2)
`define RFC_ADDR_NET_SEL (`RFC_IDX_NET_SEL << 2)
`define RFC_ADDR_TMR_EN 8'hc0
`define RFC_ADDR_CNT0 8'hc4
`define RFC_ADDR_CNT1 8'hc8
`define RFC_ADDR_CNT2 8'hcc
`define RFC_ADDR_WIN 8'hd0
`define RFC_ADDR_STATUS 8'hd4
`define RFC_ADDR_IRQ_EN 8'hd8
// ****************************************
// Fields and reset values
// ****************************************
`define RFC_MODE_HI 7
`define RFC_MODE_LO 6
`define RFC_SEL_HI 5
`define RFC_SEL_LO 4
`define RFC_PRESC_HI 2
`define RFC_PRESC_LO 0
`define RFC_EN_WIN 3
`define RFC_ST_DONE 2
`define RFC_ST_STOP 3
`define RFC_ST_GATE 4
`define RFC_STOP_MODE_RST 8'h00
`define RFC_NET_SEL_RST 8'h00
`define RFC_AXI_OKAY 2'b00
`define RFC_AXI_DECERR 2'b11
`endif

// File: inc/rfc_pkg.sv
// Types of the RC frequency counter
package rfc_pkg;
    typedef enum logic [1:0] {
        RFC_STOP_OFF,
        RFC_STOP_UNDERFLOW,
        RFC_STOP_FB_CYCLE,
        RFC_STOP_WIN_CYCLE
    } rfc_stop_mode_t;
    typedef enum logic [1:0] {
        RFC_NET_OFF,
        RFC_NET_REF,
        RFC_NET_FIRST,
        RFC_NET_SECOND
    } rfc_net_t;
    typedef enum {
        RFC_IDLE,
        RFC_ARMED,
        RFC_GATE,
        RFC_DONE
    } rfc_state_t;
endpackage

// File: design/rfc_sync_fall.sv
// Two-stage synchroniser with falling-edge detector
`timescale 1ns/1ns
module rfc_sync_fall (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous input
    input wire logic async_in,
    // Synchronised level and fall pulse
    output logic level,
    output logic fall
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign fall = prev_reg & ~sync_reg; // [R17]
endmodule // rfc_sync_fall

// File: design/rfc_down_counter.sv
// One loadable down-counting stage of the chained counter
`timescale 1ns/1ns
module rfc_down_counter #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Preload
    input wire logic load,
    input wire logic [W-1:0] load_value,
    // Count
    input wire logic dec,
    output logic [W-1:0] value,
    output logic borrow
);
    initial begin
        if (W < 1) $error("rfc_down_counter: W must be positive");
    end

    logic [W-1:0] value_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value_reg <= '0;
        end else if (load) begin
            value_reg <= load_value;
        end else if (dec) begin
            value_reg <= value_reg - W'(1); // [R3]
        end
    end

    assign value = value_reg;
    assign borrow = dec & (value_reg == '0); // [R18]
endmodule // rfc_down_counter

// File: verif/rfc_rc_net.sv
// RC network model closing the oscillator loop through the feedback pin
`timescale 1ns/1ns
module rfc_rc_net #(
    parameter int HALF_NS = 400
) (
    // Network pins
    input wire logic ref_d,
    input wire logic ref_en,
    input wire logic first_d,
    input wire logic first_en,
    input wire logic second_d,
    input wire logic second_en,
    // Capacitor node and double-drive flag
    output logic fb_node,
    output logic clash
);
    logic lvl;
    initial begin
        fb_node = 1'b0;
        lvl = 1'b0;
        clash = 1'b0;
    end
    // Undriven node discharges to ground
    always @(*) begin
        if (ref_en) lvl = ref_d;
        else if (first_en) lvl = first_d;
        else if (second_en) lvl = second_d;
        else lvl = 1'b0;
        if (ref_en + first_en + second_en > 2'd1) clash = 1'b1;
    end
    // Node follows the driven level after the RC delay
    always @(lvl) fb_node <= #HALF_NS lvl;
endmodule // rfc_rc_net

// File: verif/test_rfc_top.sv
// Self-checking bench of the RC frequency counter
`timescale 1ns/1ns
module test_rfc_top;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, window_timer_clock, osc_feedback_input;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, measure_stop_flag, irq, clash;
    logic ref_resistor_drive, ref_drive_enable, first_sensor_drive;
    logic first_sensor_enable, second_sensor_drive, second_sensor_enable;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [23:0] v;
    int num_errors, comparisons, falls, t_fall, cxp, wcnt, stop_len, f0, p;
    wire [2:0] en = {second_sensor_enable, first_sensor_enable,
        ref_drive_enable};
    rfc_top DUT (.*);
    rfc_rc_net u_net (
        .ref_d(ref_resistor_drive),
        .ref_en(ref_drive_enable),
        .first_d(first_sensor_drive),
        .first_en(first_sensor_enable),
        .second_d(second_sensor_drive),
        .second_en(second_sensor_enable),
        .fb_node(osc_feedback_input),
        .clash(clash)
    );
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // Feedback fall count and period in ns
    always @(negedge osc_feedback_input) begin
        falls++;
        cxp = int'($time) - t_fall;
        t_fall = int'($time);
    end
    // Window clock of 80 cycles, stop flag high time
    always @(posedge aclk) begin
        wcnt <= (wcnt == 39) ? 0 : wcnt + 1;
        if (wcnt == 39) window_timer_clock <= ~window_timer_clock;
        if (measure_stop_flag) stop_len <= stop_len + 1;
    end
    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Count compared within a tolerance
    task automatic near(input string nm, input logic [31:0] seen,
        input int exp, tol);
        int d;
        d = int'(seen) - exp;
        check(nm, (!$isunknown(seen) && d <= tol && d >= -tol) ? exp : seen,
            exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic wait_done;
        do rd_reg(8'hd4); while (rd[2] !== 1'b1);
        @(posedge aclk);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        aresetn = 1'b0;
        window_timer_clock = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        void'($urandom(32'hd924));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(8'h04);
        check("mode_rst", rd, 0);
        rd_reg(8'hbc);
        check("net_rst", rd, 0);
        rd_reg(8'h80);
        check("unmapped", rs, 2'b11);
        for (int s = 0; s < 4; s++) begin
            wr(8'hbc, s << 4);
            check("bresp", rs, 0);
            f0 = falls;
            repeat (200) @(posedge aclk);
            check("net_en", en, (s == 0) ? 0 : 1 << (s - 1));
            check("osc", falls > f0, s != 0);
        end
        p = 100 + $urandom % 100;
        wr(8'hc4, p);
        f0 = falls;
        wr(8'hc0, 1);
        repeat (300) @(posedge aclk);
        wr(8'hc0, 0);
        rd_reg(8'hc4);
        near("free", rd, p - (falls - f0), 2);
        wr(8'hd8, 4);
        wr(8'h04, 8'h80);
        wr(8'hc4, 0);
        wr(8'hc8, 0);
        wr(8'hcc, 1);
        wr(8'hc0, 7);
        wait_done();
        check("irq", irq, 1'b1);
        check("stop", measure_stop_flag, 1'b1);
        for (int i = 0; i < 3; i++) begin
            rd_reg(8'(8'hc4 + 4 * i));
            v[8 * i +: 8] = rd[7:0];
        end
        near("cnt24", v, 32'h10000 - cxp / 40, 3);
        wr(8'hd4, 4);
        wr(8'hc0, 0);
        check("irq_clr", irq, 1'b0);
        wr(8'h04, 8'h40);
        wr(8'hc4, 200);
        wr(8'hd0, 3);
        wr(8'hc0, 1);
        repeat (200) @(posedge aclk);
        rd_reg(8'hc4);
        check("armed", rd, 200);
        wr(8'hc0, 9);
        wait_done();
        rd_reg(8'hd0);
        check("win_zero", rd, 0);
        rd_reg(8'hc4);
        near("win", rd, 200 - 9600 / cxp, 6400 / cxp + 2);
        wr(8'hd4, 4);
        wr(8'hc0, 0);
        wr(8'hd8, 0);
        wr(8'h04, 8'hc0);
        wr(8'hc4, 200);
        f0 = stop_len;
        wr(8'hc0, 1);
        wait_done();
        check("pulse", stop_len - f0, 1);
        check("irq_mask", irq, 1'b0);
        rd_reg(8'hc4);
        near("wclk", rd, 200 - 3200 / cxp, 2);
        wr(8'hd8, 4);
        @(posedge aclk);
        check("irq_unmask", irq, 1'b1);
        check("clash", clash, 1'b0);
        tally_and_finish();
    end
    initial begin
        repeat (30000) @(posedge aclk);
        num_errors++;
        tally_and_finish();
    end
endmodule // test_rfc_top
